// ### inc/wbps_if.sv
// interface joining host and device power enables
`timescale 1ns/1ps
interface wbps_if;
    logic wlan_power_enable;
    logic bt_power_enable;
    logic core_supply;
    logic io_supply;
    modport host (output wlan_power_enable, output bt_power_enable,
        input core_supply, input io_supply);
    modport device (input wlan_power_enable, input bt_power_enable,
        output core_supply, output io_supply);
endinterface

// ### inc/wbps_pkg.sv
// package of constants for the wlan/bt power enable sequencer
// ==================================================================
// Overview of operation
// [RULE1] regulators on when either enable high
// [RULE2] regulators off when both enables low
// [RULE3] wlan section reset follows wlan enable
// [RULE4] bt section reset while bt enable low
// [RULE5] receiver shares bt reset; host enables bt
// [RULE6] power-on reset released within 110 ms
// [RULE7] host waits 150 ms before bus access
// [RULE8] host waits 10 ms after both low
// [RULE9] all host delays are minimums only
package wbps_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned POR_MAX_MS = 110;
    localparam int unsigned BUS_WAIT_MS = 150;
    localparam int unsigned OFF_WAIT_MS = 10;
    // all three times use the same division, CLK_HZ / 1000 = 125000 cycles per ms exactly, so none rounds
    localparam int unsigned POR_CYC = (CLK_HZ / 1000) * POR_MAX_MS;
    localparam int unsigned BUS_CYC = (CLK_HZ / 1000) * BUS_WAIT_MS;
    localparam int unsigned OFF_CYC = (CLK_HZ / 1000) * OFF_WAIT_MS;
    localparam int unsigned CNT_W = 32;
    typedef enum logic [3:0] {
        WBPS_ST_OFF = 4'b0001,
        WBPS_ST_POR = 4'b0010,
        WBPS_ST_RUN = 4'b0100,
        WBPS_ST_DIS = 4'b1000
    } wbps_state_t;
endpackage

// ### rtl/wbps_device.sv
// device end: regulator enable, power-on reset and section resets
`timescale 1ns/1ps
module wbps_device #(
    parameter int unsigned POR_CYC = wbps_pkg::POR_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    wbps_if.device link,
    output logic regulator_on,
    output logic por_active,
    output logic wlan_reset,
    output logic bt_reset,
    output logic rx_reset
);

    // ==============================================================
    // section and supply indices
    localparam int unsigned NUM_SECT = 2;
    localparam int unsigned SECT_WL = 0;
    localparam int unsigned SECT_BT = 1;

    localparam int unsigned NUM_SUP = 2;
    localparam int unsigned SUP_CORE = 0;
    localparam int unsigned SUP_IO = 1;

    // ==============================================================
    // power state
    wbps_pkg::wbps_state_t st_ff;
    wbps_pkg::wbps_state_t nxt_st;

    // ==============================================================
    // regulator and supplies
    logic reg_on_ff;
    logic nxt_reg_on;
    logic [NUM_SUP-1:0] sup_ff;

    // ==============================================================
    // power-on reset
    logic por_ff;
    logic nxt_por;
    logic [wbps_pkg::CNT_W-1:0] por_cnt_ff;
    logic [wbps_pkg::CNT_W-1:0] nxt_por_cnt;
    logic [wbps_pkg::CNT_W-1:0] por_last;
    logic por_done;

    // ==============================================================
    // section resets
    logic [NUM_SECT-1:0] sect_en;
    logic [NUM_SECT-1:0] sect_rst_ff;
    logic [NUM_SECT-1:0] nxt_sect_rst;
    logic rx_rst_ff;
    logic in_reset;

    // ==============================================================
    // enable decode
    logic wl_en;
    logic bt_en;
    logic any_en;
    logic st_por;
    logic go_up;
    logic go_down;
    logic por_end;

    assign wl_en = link.wlan_power_enable;
    assign bt_en = link.bt_power_enable;
    assign any_en = wl_en | bt_en; // [RULE1] [RULE2]
    assign st_por = (st_ff == wbps_pkg::WBPS_ST_POR);

    assign go_up = any_en; // [RULE1]
    assign go_down = ~any_en; // [RULE2]
    assign por_end = por_done & any_en; // [RULE6]

    // ==============================================================
    // power state machine
    always_comb begin
        nxt_st = st_ff;

        case (st_ff)
            wbps_pkg::WBPS_ST_OFF: begin
                if (go_up) begin
                    nxt_st = wbps_pkg::WBPS_ST_POR; // [RULE1]
                end
            end

            wbps_pkg::WBPS_ST_POR: begin
                if (go_down) begin
                    nxt_st = wbps_pkg::WBPS_ST_DIS; // [RULE2]
                end else if (por_end) begin
                    nxt_st = wbps_pkg::WBPS_ST_RUN; // [RULE6]
                end
            end

            wbps_pkg::WBPS_ST_RUN: begin
                if (go_down) begin
                    nxt_st = wbps_pkg::WBPS_ST_DIS; // [RULE2]
                end
            end

            wbps_pkg::WBPS_ST_DIS: begin
                if (go_up) begin
                    nxt_st = wbps_pkg::WBPS_ST_POR; // [RULE1]
                end else begin
                    nxt_st = wbps_pkg::WBPS_ST_OFF;
                end
            end

            default: begin
                nxt_st = wbps_pkg::WBPS_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= wbps_pkg::WBPS_ST_OFF;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==============================================================
    // regulator: on while either enable is high
    assign nxt_reg_on = any_en; // [RULE1] [RULE2]

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_on_ff <= 1'b0;
        end else begin
            reg_on_ff <= nxt_reg_on; // [RULE1] [RULE2]
        end
    end

    // ==============================================================
    // supplies: one flop each, both loaded from nxt_reg_on alongside the regulator flop
    for (genvar s = 0; s < NUM_SUP; s++) begin : g_sup
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                sup_ff[s] <= 1'b0;
            end else begin
                sup_ff[s] <= nxt_reg_on;
            end
        end
    end

    // ==============================================================
    // power-on reset: counter restarts on every power-up
    assign por_last = POR_CYC[wbps_pkg::CNT_W-1:0] - 1'b1;
    assign por_done = (por_cnt_ff >= por_last);

    assign nxt_por_cnt = !st_por ? '0 : (por_done ? por_cnt_ff : por_cnt_ff + 1'b1);
    assign nxt_por = (nxt_st != wbps_pkg::WBPS_ST_RUN); // [RULE6]

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            por_cnt_ff <= '0;
        end else begin
            por_cnt_ff <= nxt_por_cnt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            por_ff <= 1'b1;
        end else begin
            por_ff <= nxt_por; // [RULE6]
        end
    end

    // ==============================================================
    // section resets: held in power-on reset or while own enable low
    assign in_reset = por_ff | ~reg_on_ff;

    assign sect_en[SECT_WL] = wl_en;
    assign sect_en[SECT_BT] = bt_en;

    for (genvar g = 0; g < NUM_SECT; g++) begin : g_sect
        assign nxt_sect_rst[g] = in_reset | ~sect_en[g]; // [RULE3] [RULE4]

        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                sect_rst_ff[g] <= 1'b1;
            end else begin
                sect_rst_ff[g] <= nxt_sect_rst[g]; // [RULE3] [RULE4]
            end
        end
    end

    // ==============================================================
    // receiver reset, same control as the bt section
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_rst_ff <= 1'b1;
        end else begin
            rx_rst_ff <= nxt_sect_rst[SECT_BT]; // [RULE5]
        end
    end

    // ==============================================================
    // outputs, all straight from flops
    assign link.core_supply = sup_ff[SUP_CORE];
    assign link.io_supply = sup_ff[SUP_IO];

    assign regulator_on = reg_on_ff;
    assign por_active = por_ff;
    assign wlan_reset = sect_rst_ff[SECT_WL]; // [RULE3]
    assign bt_reset = sect_rst_ff[SECT_BT]; // [RULE4]
    assign rx_reset = rx_rst_ff; // [RULE5]
endmodule

// ### rtl/wbps_host.sv
// host end: drives enables, keeps minimum waits
`timescale 1ns/1ps
module wbps_host #(
    parameter int unsigned BUS_CYC = wbps_pkg::BUS_CYC,
    parameter int unsigned OFF_CYC = wbps_pkg::OFF_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    wbps_if.host link,
    input wire logic wlan_want,
    input wire logic bt_want,
    output logic bus_ready,
    output logic wlan_en_out,
    output logic bt_en_out
);
    // ==============================================================
    // sequencing state machine
    wbps_pkg::wbps_state_t st_ff;
    wbps_pkg::wbps_state_t nxt_st;
    logic [wbps_pkg::CNT_W-1:0] cnt_ff;
    logic wl_ff;
    logic bt_ff;
    logic rdy_ff;
    wire supplies_up = link.core_supply & link.io_supply;
    wire any_want = wlan_want | bt_want;
    // [RULE9] counters end at or beyond minimum
    wire bus_done = cnt_ff >= BUS_CYC[wbps_pkg::CNT_W-1:0] - 1'b1;
    wire off_done = cnt_ff >= OFF_CYC[wbps_pkg::CNT_W-1:0] - 1'b1;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            wbps_pkg::WBPS_ST_OFF: if (any_want) nxt_st = wbps_pkg::WBPS_ST_POR;
            wbps_pkg::WBPS_ST_POR: begin
                if (!any_want) nxt_st = wbps_pkg::WBPS_ST_DIS;
                else if (bus_done && supplies_up) nxt_st = wbps_pkg::WBPS_ST_RUN; // [RULE7]
            end
            wbps_pkg::WBPS_ST_RUN: if (!any_want) nxt_st = wbps_pkg::WBPS_ST_DIS;
            wbps_pkg::WBPS_ST_DIS: if (off_done) nxt_st = wbps_pkg::WBPS_ST_OFF; // [RULE8]
            default: nxt_st = wbps_pkg::WBPS_ST_OFF;
        endcase
    end

    wire enables_on = (nxt_st == wbps_pkg::WBPS_ST_POR) || (nxt_st == wbps_pkg::WBPS_ST_RUN);
    wire cnt_clear = (nxt_st != st_ff) || (st_ff == wbps_pkg::WBPS_ST_POR && !supplies_up);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= wbps_pkg::WBPS_ST_OFF;
            cnt_ff <= '0;
            wl_ff <= 1'b0;
            bt_ff <= 1'b0;
            rdy_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= cnt_clear ? '0 : cnt_ff + 1'b1;
            wl_ff <= enables_on & wlan_want;
            bt_ff <= enables_on & bt_want; // [RULE5]
            rdy_ff <= (nxt_st == wbps_pkg::WBPS_ST_RUN) & wlan_want; // [RULE7]
        end
    end

    assign link.wlan_power_enable = wl_ff;
    assign link.bt_power_enable = bt_ff;
    assign wlan_en_out = wl_ff;
    assign bt_en_out = bt_ff;
    assign bus_ready = rdy_ff;
endmodule

// ### verif/test_wlan_bt_power_enable_sequencer.sv
// self-checking bench for the power enable sequencer
`timescale 1ns/1ps
module test_wlan_bt_power_enable_sequencer;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wlan_want = 1'b0;
    logic bt_want = 1'b0;
    logic regulator_on, por_active, wlan_reset, bt_reset, rx_reset;
    logic bus_ready, wlan_en_out, bt_en_out;
    logic [31:0] v;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 32'h2038_1722;
    wbps_if link ();
    always #4 core_clk = ~core_clk;
    wbps_device #(.POR_CYC(20)) i_wbps_device (.core_clk(core_clk), .sys_rst(sys_rst),
        .link(link), .regulator_on(regulator_on), .por_active(por_active),
        .wlan_reset(wlan_reset), .bt_reset(bt_reset), .rx_reset(rx_reset));
    wbps_host #(.BUS_CYC(40), .OFF_CYC(10)) i_wbps_host (.core_clk(core_clk),
        .sys_rst(sys_rst), .link(link), .wlan_want(wlan_want), .bt_want(bt_want),
        .bus_ready(bus_ready), .wlan_en_out(wlan_en_out), .bt_en_out(bt_en_out));
    wbps_asserts #(.OFF_CYC(10)) i_wbps_asserts (.core_clk(core_clk), .sys_rst(sys_rst),
        .wlan_power_enable(link.wlan_power_enable), .bt_power_enable(link.bt_power_enable),
        .core_supply(link.core_supply), .io_supply(link.io_supply));
    // ==================================================================
    // expectations and checks
    function automatic logic exp_reset(input logic want);
        return ~want;
    endfunction
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic results;
        $display("checked=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apply(input logic w, input logic b);
        @(negedge core_clk);
        wlan_want = w;
        bt_want = b;
        repeat (60) @(negedge core_clk);
        chk(regulator_on, w | b);
        chk(wlan_reset, exp_reset(w));
        chk(bt_reset, exp_reset(b));
        chk(rx_reset, exp_reset(b));
        chk(por_active, exp_reset(w | b));
        chk(bus_ready, w);
        chk(wlan_en_out, w);
        chk(bt_en_out, b);
        chk(link.core_supply, w | b);
        chk(link.io_supply, w | b);
    endtask
    // ==================================================================
    // main sequence and watchdog
    initial begin
        repeat (16) @(negedge core_clk);
        sys_rst = 1'b0;
        apply(1'b1, 1'b0);
        apply(1'b0, 1'b0);
        apply(1'b0, 1'b1);
        apply(1'b1, 1'b1);
        // short off pulse: host must hold enables low for the off gap
        wlan_want = 1'b0;
        bt_want = 1'b0;
        repeat (2) @(negedge core_clk);
        wlan_want = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(wlan_en_out, 1'b0);
        // reset in mid-run
        sys_rst = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(por_active, 1'b1);
        chk(regulator_on, 1'b0);
        chk(bus_ready, 1'b0);
        sys_rst = 1'b0;
        apply(1'b1, 1'b0);
        for (int i = 0; i < 16; i++) begin
            v = $random(seed);
            apply(v[0], v[1]);
        end
        results();
    end
    initial begin
        #30000;
        err_total++;
        results();
    end
endmodule

// ### verif/wbps_asserts.sv
// concurrent checks on the power enable wires
`timescale 1ns/1ps
module wbps_asserts #(
    parameter int unsigned OFF_CYC = wbps_pkg::OFF_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wlan_power_enable,
    input wire logic bt_power_enable,
    input wire logic core_supply,
    input wire logic io_supply
);
    // ==================================================================
    // off gap on the enables, and supplies against enables
    wire any_en = wlan_power_enable | bt_power_enable;
    // cycles both enables have been low, saturating
    logic [wbps_pkg::CNT_W-1:0] low_cnt_ff;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            low_cnt_ff <= OFF_CYC[wbps_pkg::CNT_W-1:0];
        end else if (any_en) begin
            low_cnt_ff <= '0;
        end else if (low_cnt_ff < OFF_CYC[wbps_pkg::CNT_W-1:0]) begin
            low_cnt_ff <= low_cnt_ff + 1'b1;
        end
    end
    off_gap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(any_en) |-> low_cnt_ff >= OFF_CYC[wbps_pkg::CNT_W-1:0])
        else $error("enables raised before off gap");
    supply_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(core_supply) |-> !$past(any_en)) else $error("supply dropped unasked");
    supply_on_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        any_en |=> core_supply) else $error("supply not on after enable");
    supply_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !any_en |=> !core_supply && !io_supply) else $error("supply not off");
    supply_pair_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        core_supply == io_supply) else $error("supplies disagree");
    supply_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(core_supply) |-> $past(any_en)) else $error("supply rose unasked");
    off_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(any_en) |-> (!any_en)[*8]) else $error("enable raised too soon");
endmodule
